/* verilog/tas_top.v */
// Touch converter sequencer with Avalon-MM register slave
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "tas_defs.vh"
module tas_top (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Panel and converter
  input wire pen_touch_n,
  input wire [11:0] adc_sample,
  output reg yminus_ground,
  output reg xplus_pullup_on,
  output reg y_drivers_on,
  output reg x_drivers_on,
  output reg z_drivers_on,
  output reg precharge_on,
  output reg adc_power_on,
  output reg [2:0] adc_channel,
  output reg ratiometric,
  // Reference
  output reg ref_enable,
  output reg ref_high,
  // Clocking and power
  input wire audio_dac_powered,
  input wire audio_tick,
  input wire hw_powerdown,
  output reg osc_enable,
  // Host interrupt
  output reg touch_or_result_ready_n
);
  localparam S_IDLE = 5'b00001;
  localparam S_DRIVE = 5'b00010;
  localparam S_CONV = 5'b00100;
  localparam S_PRE = 5'b01000;
  localparam S_SENSE = 5'b10000;

  reg [15:0] converter_control_word;
  reg [15:0] converter_status_word;
  reg [15:0] reference_word;
  reg [15:0] touch_detect_timing_word;
  reg [11:0] res_mem [0:4];
  reg [4:0] state;
  reg [2:0] ch;
  reg [2:0] last_ch;
  reg [4:0] run_mask;
  reg [11:0] dly;
  reg [15:0] acc;
  reg [4:0] avg_left;
  reg conv_start;
  reg host_start;
  reg [3:0] host_scan;
  reg [4:0] unread;
  reg pen_hold;
  reg set_done;
  reg [31:0] rd_mux;
  wire base_tick;
  wire conv_done;
  wire [11:0] conv_result;
  wire bus_req;
  wire [15:0] avg_val;
  wire rd_take;
  wire wr_take;
  wire host_mode;
  wire [3:0] scan;
  wire pen_det;
  wire self_start;
  wire start_now;
  wire [3:0] start_scan;
  wire [4:0] rd_clear;
  wire [15:0] acc_sum;
  wire touch_phase;

  function [11:0] dly_ticks;
    input [2:0] code;
    begin
      dly_ticks = `TAS_DLY_BASE << code;
    end
  endfunction

  function [2:0] avg_shift;
    input [1:0] code;
    begin
      case (code)
        2'h1: avg_shift = 3'h2;
        2'h2: avg_shift = 3'h3;
        2'h3: avg_shift = 3'h4;
        default: avg_shift = 3'h0;
      endcase
    end
  endfunction

  function [4:0] scan_mask;
    input [3:0] s;
    begin
      case (s)
        `TAS_SCAN_XY: scan_mask = `TAS_MASK_XY;
        `TAS_SCAN_XYZ: scan_mask = `TAS_MASK_XYZ;
        `TAS_SCAN_BAT: scan_mask = `TAS_MASK_BAT;
        default: scan_mask = 5'h00;
      endcase
    end
  endfunction

  tas_conv tas_conv_i (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .audio_powered(audio_dac_powered),
    .audio_tick(audio_tick),
    .div(converter_control_word[`TAS_C_DIV]),
    .res(converter_control_word[`TAS_C_RES]),
    .start(conv_start),
    .sample_in(adc_sample),
    .base_tick(base_tick),
    .done(conv_done),
    .result(conv_result)
  );

  assign bus_req = avs_read || avs_write;
  assign avg_val = acc_sum >> avg_shift(converter_control_word[`TAS_C_AVG]);
  assign rd_take = avs_read && !avs_waitrequest;
  assign wr_take = avs_write && !avs_waitrequest;
  assign host_mode = converter_control_word[`TAS_C_HOST];
  assign scan = converter_control_word[`TAS_C_SCAN];
  assign pen_det = (state == S_IDLE) && !hw_powerdown && !pen_touch_n;
  assign self_start = pen_det && !host_mode &&
    ((scan == `TAS_SCAN_XY) || (scan == `TAS_SCAN_XYZ));
  assign start_now = (state == S_IDLE) && (self_start || host_start);
  assign start_scan = host_start ? host_scan : scan;
  assign rd_clear = (rd_take && avs_address >= `TAS_R_Y && avs_address <= `TAS_R_BAT) ?
    (5'h01 << (avs_address - `TAS_R_Y)) : 5'h00;
  assign acc_sum = acc + {4'h0, conv_result};
  assign touch_phase = (state == S_DRIVE) || (state == S_CONV);

  // Read data mux
  always @* begin
    rd_mux = 32'h0;
    case (avs_address)
      `TAS_R_CTRL: rd_mux = {16'h0, converter_control_word};
      `TAS_R_STAT: rd_mux = {16'h0, converter_status_word[`TAS_S_PIN], 1'b0,
        host_mode, state != S_IDLE, !pen_touch_n, 10'h000};
      `TAS_R_REF: rd_mux = {16'h0, reference_word};
      `TAS_R_TIM: rd_mux = {16'h0, touch_detect_timing_word};
      `TAS_R_Y: rd_mux = {20'h0, res_mem[0]};
      `TAS_R_X: rd_mux = {20'h0, res_mem[1]};
      `TAS_R_Z1: rd_mux = {20'h0, res_mem[2]};
      `TAS_R_Z2: rd_mux = {20'h0, res_mem[3]};
      `TAS_R_BAT: rd_mux = {20'h0, res_mem[4]};
      default: rd_mux = 32'h0;
    endcase
  end

  // Bus slave and registers
  always @(posedge ref_clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      converter_control_word <= `TAS_CTRL_RST;
      converter_status_word <= `TAS_STAT_RST;
      reference_word <= `TAS_REF_RST;
      touch_detect_timing_word <= `TAS_TIM_RST;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (bus_req && avs_waitrequest)
        avs_readdata <= avs_read ? rd_mux : 32'h0;
      if (wr_take) begin
        case (avs_address)
          `TAS_R_CTRL: converter_control_word <= avs_writedata[15:0];
          `TAS_R_STAT: converter_status_word <= avs_writedata[15:0];
          `TAS_R_REF: reference_word <= avs_writedata[15:0];
          `TAS_R_TIM: touch_detect_timing_word <= avs_writedata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Host start request, taken when the sequencer is idle
  always @(posedge ref_clk) begin
    if (!nrst) begin
      host_start <= 1'b0;
      host_scan <= 4'h0;
    end else if (wr_take && avs_address == `TAS_R_CTRL && avs_writedata[`TAS_C_HOST] &&
        scan_mask(avs_writedata[`TAS_C_SCAN]) != 5'h00) begin
      host_start <= 1'b1;
      host_scan <= avs_writedata[`TAS_C_SCAN];
    end else if (start_now || !host_mode) begin
      host_start <= 1'b0;
    end
  end

  // Scan sequencer
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state <= S_IDLE;
      ch <= `TAS_CH_Y;
      last_ch <= `TAS_CH_Y;
      run_mask <= 5'h00;
      dly <= 12'h000;
      acc <= 16'h0000;
      avg_left <= 5'h00;
      conv_start <= 1'b0;
      set_done <= 1'b0;
      res_mem[0] <= 12'h000;
      res_mem[1] <= 12'h000;
      res_mem[2] <= 12'h000;
      res_mem[3] <= 12'h000;
      res_mem[4] <= 12'h000;
    end else begin
      conv_start <= 1'b0;
      set_done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start_now) begin
            state <= S_DRIVE;
            run_mask <= scan_mask(start_scan);
            ch <= (start_scan == `TAS_SCAN_BAT) ? `TAS_CH_BAT : `TAS_CH_Y;
            case (start_scan)
              `TAS_SCAN_XYZ: last_ch <= `TAS_CH_Z2;
              `TAS_SCAN_BAT: last_ch <= `TAS_CH_BAT;
              default: last_ch <= `TAS_CH_X;
            endcase
            dly <= dly_ticks(touch_detect_timing_word[`TAS_T_STAB]);
          end
        end
        S_DRIVE: begin
          if (base_tick) begin
            if (dly == 12'h000) begin
              state <= S_CONV;
              conv_start <= 1'b1;
              acc <= 16'h0000;
              avg_left <= 5'h01 << avg_shift(converter_control_word[`TAS_C_AVG]);
            end else begin
              dly <= dly - 12'h001;
            end
          end
        end
        S_CONV: begin
          if (conv_done) begin
            acc <= acc_sum;
            if (avg_left == 5'h01) begin
              res_mem[ch] <= avg_val[11:0];
              if (ch == last_ch) begin
                state <= S_IDLE;
                set_done <= 1'b1;
              end else begin
                state <= S_PRE;
                dly <= dly_ticks(touch_detect_timing_word[`TAS_T_PRE]);
              end
            end else begin
              avg_left <= avg_left - 5'h01;
              conv_start <= 1'b1;
            end
          end
        end
        S_PRE: begin
          if (base_tick) begin
            if (dly == 12'h000) begin
              state <= S_SENSE;
              dly <= dly_ticks(touch_detect_timing_word[`TAS_T_SENSE]);
            end else begin
              dly <= dly - 12'h001;
            end
          end
        end
        S_SENSE: begin
          if (base_tick) begin
            if (dly != 12'h000) begin
              dly <= dly - 12'h001;
            end else if (pen_touch_n || hw_powerdown) begin
              state <= S_IDLE;
            end else begin
              state <= S_DRIVE;
              ch <= ch + 3'h1;
              dly <= dly_ticks(touch_detect_timing_word[`TAS_T_STAB]);
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Panel switches, clocks and reference
  always @(posedge ref_clk) begin
    if (!nrst) begin
      yminus_ground <= 1'b1;
      xplus_pullup_on <= 1'b1;
      y_drivers_on <= 1'b0;
      x_drivers_on <= 1'b0;
      z_drivers_on <= 1'b0;
      precharge_on <= 1'b0;
      adc_power_on <= 1'b0;
      adc_channel <= `TAS_CH_Y;
      ratiometric <= 1'b1;
      ref_enable <= 1'b0;
      ref_high <= 1'b0;
      osc_enable <= 1'b0;
    end else begin
      yminus_ground <= (state == S_IDLE) || (state == S_SENSE) ||
        (touch_phase && ch == `TAS_CH_Y);
      xplus_pullup_on <= ((state == S_IDLE) && !hw_powerdown) ||
        (state == S_SENSE);
      y_drivers_on <= touch_phase && ch == `TAS_CH_Y;
      x_drivers_on <= touch_phase && ch == `TAS_CH_X;
      z_drivers_on <= touch_phase && (ch == `TAS_CH_Z1 || ch == `TAS_CH_Z2);
      precharge_on <= state == S_PRE;
      adc_power_on <= state == S_CONV;
      adc_channel <= ch;
      ratiometric <= ch != `TAS_CH_BAT;
      ref_enable <= reference_word[`TAS_REF_ON] && ch == `TAS_CH_BAT;
      ref_high <= reference_word[`TAS_REF_HI];
      osc_enable <= !audio_dac_powered && (state != S_IDLE || start_now);
    end
  end

  // Touch and data-ready output
  always @(posedge ref_clk) begin
    if (!nrst) begin
      unread <= 5'h00;
      pen_hold <= 1'b0;
      touch_or_result_ready_n <= 1'b1;
    end else begin
      unread <= (unread & ~rd_clear) | (set_done ? run_mask : 5'h00);
      if (pen_det)
        pen_hold <= 1'b1;
      else if (set_done)
        pen_hold <= 1'b0;
      case (converter_status_word[`TAS_S_PIN])
        `TAS_PIN_PEN: touch_or_result_ready_n <= !pen_det;
        `TAS_PIN_DAV: touch_or_result_ready_n <= (unread == 5'h00);
        default: touch_or_result_ready_n <= set_done || !(pen_det || pen_hold);
      endcase
    end
  end
endmodule // tas_top
`default_nettype wire

/* verilog/tas_defs.vh */
// Constants for the touch converter sequencer
`ifndef TAS_DEFS_VH
`define TAS_DEFS_VH
`define TAS_REF_HZ 32'd50000000
`define TAS_OSC_HZ 32'd8000000
`define TAS_SAMPLE_CLKS 5'h03
`define TAS_DLY_BASE 12'h010
`define TAS_R_CTRL 4'h0
`define TAS_R_STAT 4'h1
`define TAS_R_REF 4'h2
`define TAS_R_TIM 4'h3
`define TAS_R_Y 4'h4
`define TAS_R_X 4'h5
`define TAS_R_Z1 4'h6
`define TAS_R_Z2 4'h7
`define TAS_R_BAT 4'h8
`define TAS_CTRL_RST 16'h0000
`define TAS_STAT_RST 16'h0000
`define TAS_REF_RST 16'h0000
`define TAS_TIM_RST 16'h0000
`define TAS_C_HOST 15
`define TAS_C_SCAN 13:10
`define TAS_C_RES 9:8
`define TAS_C_AVG 7:6
`define TAS_C_DIV 5:4
`define TAS_S_PIN 15:14
`define TAS_REF_ON 1
`define TAS_REF_HI 0
`define TAS_T_STAB 10:8
`define TAS_T_PRE 5:3
`define TAS_T_SENSE 2:0
`define TAS_SCAN_XY 4'h1
`define TAS_SCAN_XYZ 4'h2
`define TAS_SCAN_BAT 4'h3
`define TAS_RES_12 2'h0
`define TAS_RES_8 2'h1
`define TAS_RES_10 2'h2
`define TAS_CH_Y 3'h0
`define TAS_CH_X 3'h1
`define TAS_CH_Z1 3'h2
`define TAS_CH_Z2 3'h3
`define TAS_CH_BAT 3'h4
`define TAS_PIN_PEN 2'h0
`define TAS_PIN_DAV 2'h1
`define TAS_MASK_XY 5'h03
`define TAS_MASK_XYZ 5'h0F
`define TAS_MASK_BAT 5'h10
`endif

/* verilog/tas_conv.v */
// Converter clocking and conversion timing
`timescale 1ns/1ps
`default_nettype none
`include "tas_defs.vh"
module tas_conv (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Clock source
  input wire audio_powered,
  input wire audio_tick,
  input wire [1:0] div,
  input wire [1:0] res,
  // Conversion
  input wire start,
  input wire [11:0] sample_in,
  output reg base_tick,
  output reg done,
  output reg [11:0] result
);
  reg [31:0] phase;
  reg [2:0] div_cnt;
  reg [4:0] cnt;
  reg busy;
  wire [31:0] next_phase;
  wire src_tick;
  wire conv_tick;

  function [4:0] res_bits;
    input [1:0] r;
    begin
      case (r)
        `TAS_RES_8: res_bits = 5'h08;
        `TAS_RES_10: res_bits = 5'h0A;
        default: res_bits = 5'h0C;
      endcase
    end
  endfunction

  assign next_phase = phase + `TAS_OSC_HZ;
  assign src_tick = audio_powered ? audio_tick : base_tick;
  assign conv_tick = src_tick && (div_cnt == ((3'h1 << div) - 3'h1));

  always @(posedge ref_clk) begin
    if (!nrst) begin
      phase <= 32'h0;
      base_tick <= 1'b0;
      div_cnt <= 3'h0;
      cnt <= 5'h00;
      busy <= 1'b0;
      done <= 1'b0;
      result <= 12'h000;
    end else begin
      // Oscillator stopped while audio clocks run
      if (audio_powered) begin
        phase <= 32'h0;
        base_tick <= audio_tick;
      end else if (next_phase >= `TAS_REF_HZ) begin
        phase <= next_phase - `TAS_REF_HZ;
        base_tick <= 1'b1;
      end else begin
        phase <= next_phase;
        base_tick <= 1'b0;
      end
      // Programmed divider for the converter clock
      if (conv_tick)
        div_cnt <= 3'h0;
      else if (src_tick)
        div_cnt <= div_cnt + 3'h1;
      done <= 1'b0;
      // Fewer bits, fewer converter clocks
      if (start) begin
        busy <= 1'b1;
        cnt <= res_bits(res) + `TAS_SAMPLE_CLKS;
      end else if (busy && conv_tick) begin
        if (cnt == 5'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= sample_in >> (5'h0C - res_bits(res));
        end
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule // tas_conv
`default_nettype wire

/* tb/tas_top_monitor.sv */
// Port checker for the touch converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tas_top_monitor (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Register bus
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Panel and converter
  input wire pen_touch_n,
  input wire yminus_ground,
  input wire xplus_pullup_on,
  input wire y_drivers_on,
  input wire x_drivers_on,
  input wire z_drivers_on,
  input wire precharge_on,
  input wire adc_power_on,
  input wire [2:0] adc_channel,
  input wire ratiometric,
  input wire ref_enable,
  // Power and interrupt
  input wire audio_dac_powered,
  input wire hw_powerdown,
  input wire osc_enable,
  input wire touch_or_result_ready_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [1:0] fn;
  // Copy of the output function field
  always @(posedge ref_clk) begin
    if (!nrst) fn <= 2'h0;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h1) fn <= avs_writedata[15:14];
  end
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer late");
  property p_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_pulse: assert property (p_pulse) else $error("wait low too long");
  property p_rdata;
    avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000
      && (avs_address <= 4'h8 || avs_readdata == 32'h0);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data bad");
  property p_nopull;
    y_drivers_on || x_drivers_on |-> !xplus_pullup_on;
  endproperty
  a_nopull: assert property (p_nopull) else $error("pull-up during position");
  property p_pre;
    precharge_on |-> !y_drivers_on && !x_drivers_on && !z_drivers_on;
  endproperty
  a_pre: assert property (p_pre) else $error("drivers during precharge");
  property p_ratio;
    adc_channel != 3'h4 |-> ratiometric;
  endproperty
  a_ratio: assert property (p_ratio) else $error("touch not ratiometric");
  property p_ref;
    ref_enable |-> adc_channel == 3'h4;
  endproperty
  a_ref: assert property (p_ref) else $error("reference on touch");
  property p_osc;
    $past(audio_dac_powered) |-> !osc_enable;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator with audio");
  property p_pen00;
    fn == 2'h0 && $stable(fn) && !touch_or_result_ready_n |-> $past(pen_touch_n) == 1'b0;
  endproperty
  a_pen00: assert property (p_pen00) else $error("pen irq without touch");
  property p_pdown;
    fn == 2'h0 && hw_powerdown && $past(hw_powerdown) && $past(hw_powerdown, 2)
      |-> touch_or_result_ready_n;
  endproperty
  a_pdown: assert property (p_pdown) else $error("detect in power-down");
  property p_ground;
    !(x_drivers_on || z_drivers_on || adc_power_on || precharge_on) && adc_channel != 3'h4
      |-> yminus_ground;
  endproperty
  a_ground: assert property (p_ground) else $error("Y minus not grounded");
  c_irq: cover property ($fell(touch_or_result_ready_n));
  c_z: cover property ($rose(z_drivers_on));
  c_pre: cover property ($rose(precharge_on));
endmodule // tas_top_monitor
`default_nettype wire

/* tb/tas_panel.sv */
// Four-wire panel and analog front end model
`timescale 1ns/1ps
`default_nettype none
module tas_panel #(
  parameter logic [11:0] Y_VAL = 12'h3A5,
  parameter logic [11:0] X_VAL = 12'h5C3,
  parameter logic [11:0] Z1_VAL = 12'h1E7,
  parameter logic [11:0] Z2_VAL = 12'hB48,
  parameter logic [11:0] BAT_VAL = 12'h7D2
) (
  // Clock and stylus
  input wire ref_clk,
  input wire pressed,
  // Panel switches
  input wire xplus_pullup_on,
  input wire yminus_ground,
  input wire y_drivers_on,
  input wire x_drivers_on,
  input wire z_drivers_on,
  input wire [2:0] adc_channel,
  // Sensed values
  output logic pen_touch_n,
  output logic [11:0] adc_sample
);
  logic flip = 1'b0;
  logic [11:0] junk;
  always @(posedge ref_clk) flip <= !flip;
  assign junk = {12{flip}};
  // Undriven sense line wanders
  assign pen_touch_n = !xplus_pullup_on ? flip : !(pressed && yminus_ground);
  always_comb begin
    case (adc_channel)
      3'h0: adc_sample = y_drivers_on ? Y_VAL : junk;
      3'h1: adc_sample = x_drivers_on ? X_VAL : junk;
      3'h2: adc_sample = z_drivers_on ? Z1_VAL : junk;
      3'h3: adc_sample = z_drivers_on ? Z2_VAL : junk;
      3'h4: adc_sample = BAT_VAL;
      default: adc_sample = junk;
    endcase
  end
endmodule // tas_panel
`default_nettype wire

/* tb/tas_top_bench.sv */
// Self-checking bench for the touch converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tas_top_bench;
  localparam logic [31:0] YV = 32'h3A5, XV = 32'h5C3, Z1V = 32'h1E7, Z2V = 32'hB48, BV = 32'h7D2;
  logic ref_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, pressed = 1'b0;
  logic audio_dac_powered = 1'b0, audio_tick = 1'b0, hw_powerdown = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, pen_touch_n, yminus_ground, xplus_pullup_on, y_drivers_on, x_drivers_on;
  logic z_drivers_on, precharge_on, adc_power_on, ratiometric, ref_enable, ref_high, osc_enable;
  logic touch_or_result_ready_n;
  logic [11:0] adc_sample;
  logic [2:0] adc_channel, tick_cnt = 3'h0;
  integer n_fail = 0, checks_done = 0, w;
  initial forever #10 ref_clk = ~ref_clk;
  // Audio clock ticks while audio is powered
  always @(posedge ref_clk) begin
    tick_cnt <= (tick_cnt == 3'h5) ? 3'h0 : tick_cnt + 3'h1;
    audio_tick <= audio_dac_powered && tick_cnt == 3'h0;
  end
  tas_top tas_top_i (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pen_touch_n(pen_touch_n),
    .adc_sample(adc_sample), .yminus_ground(yminus_ground), .xplus_pullup_on(xplus_pullup_on),
    .y_drivers_on(y_drivers_on), .x_drivers_on(x_drivers_on), .z_drivers_on(z_drivers_on),
    .precharge_on(precharge_on), .adc_power_on(adc_power_on), .adc_channel(adc_channel),
    .ratiometric(ratiometric), .ref_enable(ref_enable), .ref_high(ref_high),
    .audio_dac_powered(audio_dac_powered), .audio_tick(audio_tick),
    .hw_powerdown(hw_powerdown), .osc_enable(osc_enable),
    .touch_or_result_ready_n(touch_or_result_ready_n));
  tas_panel tas_panel_i (.ref_clk(ref_clk), .pressed(pressed), .xplus_pullup_on(xplus_pullup_on),
    .yminus_ground(yminus_ground), .y_drivers_on(y_drivers_on), .x_drivers_on(x_drivers_on),
    .z_drivers_on(z_drivers_on), .adc_channel(adc_channel), .pen_touch_n(pen_touch_n),
    .adc_sample(adc_sample));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic irq(input logic exp);
    chk("irq line", {31'h0, exp}, {31'h0, touch_or_result_ready_n});
  endtask
  task automatic cycles(input integer k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    integer n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) chk("bus answer", 32'h0, 32'h1);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 16'h0000);
    chk(what, exp, q);
  endtask
  task automatic wait_busy;
    integer n;
    n = 0;
    do begin
      bus(1'b0, 4'h1, 16'h0000);
      n++;
    end while (q[11] !== 1'b0 && n < 4000);
    if (n == 4000) chk("busy end", 32'h0, 32'h1);
  endtask
  task automatic wait_lvl(input logic pre, input logic v, input integer lim);
    w = 0;
    while ((pre ? precharge_on : touch_or_result_ready_n) !== v && w < lim) begin
      @(negedge ref_clk);
      w++;
    end
    if (w == lim) chk("wait level", 32'h0, 32'h1);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #1600000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    @(posedge ref_clk) nrst <= 1'b1;
    cycles(1);
    chk("idle pins", 32'h7, {29'h0, yminus_ground, xplus_pullup_on, touch_or_result_ready_n});
    for (int i = 0; i < 4; i++) rd(i[3:0], 32'h0, "reset register");
    bus(1'b1, 4'h9, 16'hFFFF);
    rd(4'h9, 32'h0, "unmapped");
    bus(1'b1, 4'h2, 16'h0001);
    rd(4'h2, 32'h1, "reference");
    chk("ref high", 32'h1, {31'h0, ref_high});
    @(posedge ref_clk) pressed <= 1'b1;
    cycles(4);
    irq(1'b0);
    @(posedge ref_clk) hw_powerdown <= 1'b1;
    cycles(4);
    irq(1'b1);
    @(posedge ref_clk) pressed <= 1'b0;
    @(posedge ref_clk) hw_powerdown <= 1'b0;
    bus(1'b1, 4'h1, 16'h5C00);
    rd(4'h1, 32'h4000, "status");
    bus(1'b1, 4'h0, 16'h0420);
    rd(4'h0, 32'h0420, "control");
    // Release before the first still-touched check
    @(posedge ref_clk) pressed <= 1'b1;
    wait_lvl(1'b1, 1'b1, 3000);
    @(posedge ref_clk) pressed <= 1'b0;
    wait_busy;
    irq(1'b1);
    rd(4'h4, YV, "y result");
    rd(4'h5, 32'h0, "x after release");
    @(posedge ref_clk) pressed <= 1'b1;
    wait_lvl(1'b0, 1'b0, 8000);
    @(posedge ref_clk) pressed <= 1'b0;
    wait_busy;
    rd(4'h4, YV, "y result");
    cycles(2);
    irq(1'b0);
    rd(4'h5, XV, "x result");
    cycles(2);
    irq(1'b1);
    bus(1'b1, 4'h1, 16'h8000);
    bus(1'b1, 4'h0, 16'h0860);
    @(posedge ref_clk) pressed <= 1'b1;
    wait_lvl(1'b0, 1'b0, 50);
    wait_lvl(1'b0, 1'b1, 20000);
    chk("irq low span", 32'h1, {31'h0, w > 4000});
    @(posedge ref_clk) pressed <= 1'b0;
    wait_busy;
    rd(4'h6, Z1V, "z1 result");
    rd(4'h7, Z2V, "z2 result");
    rd(4'h5, XV, "x result");
    bus(1'b1, 4'h0, 16'h0C20);
    @(posedge ref_clk) pressed <= 1'b1;
    cycles(40);
    bus(1'b0, 4'h1, 16'h0000);
    chk("self battery busy", 32'h0, {31'h0, q[11]});
    @(posedge ref_clk) pressed <= 1'b0;
    @(posedge ref_clk) audio_dac_powered <= 1'b1;
    bus(1'b1, 4'h2, 16'h0003);
    bus(1'b1, 4'h0, 16'h8C20);
    bus(1'b0, 4'h1, 16'h0000);
    chk("host mode bit", 32'h1, {31'h0, q[12]});
    wait_busy;
    rd(4'h8, BV, "battery result");
    bus(1'b1, 4'h0, 16'h8D00);
    wait_busy;
    rd(4'h8, BV >> 4, "battery 8 bit");
    @(posedge ref_clk) audio_dac_powered <= 1'b0;
    tally_and_finish;
  end
endmodule // tas_top_bench
bind tas_top tas_top_monitor tas_top_monitor_i (.ref_clk(ref_clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pen_touch_n(pen_touch_n), .yminus_ground(yminus_ground), .xplus_pullup_on(xplus_pullup_on),
  .y_drivers_on(y_drivers_on), .x_drivers_on(x_drivers_on), .z_drivers_on(z_drivers_on),
  .precharge_on(precharge_on), .adc_power_on(adc_power_on), .adc_channel(adc_channel),
  .ratiometric(ratiometric), .ref_enable(ref_enable), .audio_dac_powered(audio_dac_powered),
  .hw_powerdown(hw_powerdown), .osc_enable(osc_enable),
  .touch_or_result_ready_n(touch_or_result_ready_n));
`default_nettype wire
